// ===== logic/basout_top.sv
// Bus activity status output: shared status pin, write-drive strobe and
// bus direction control for an external bus shared with outside masters.
// Assumes all inputs are synchronous to CLK; the processor phase clock is
// sampled as a level, so outputs lag a phase change by two CLK edges and other inputs by one.
`timescale 1ns/100ps

// Behaviour
// - Status indicator high while processor uses internal buses.
// - Status indicator low while processor uses the external bus.
// - Write-drive strobe low in high phase when processor writes out.
// - Trace bit set: strobe in high phase, indicator in low phase.
// - Trace bit clear: indicator in low phase, one in high phase.
// - Grant low in low phase turns address and write strobe to inputs.
// - Trace bit set keeps the address bus driven while the bus is not released.
module basout_top
   import basout_pkg::*;
(
   input  wire logic CLK,
   input  wire logic SRST,
   input  wire logic PROCESSOR_PHASE_CLOCK,
   input  wire logic CPU_EXT_BUS,
   input  wire logic CPU_EXT_WRITE,
   input  wire logic CPU_WRITE_STROBE_N,
   input  wire logic EMULATION_TRACE_BIT,
   input  wire logic EXTERNAL_BUS_GRANT,
   output logic      BUS_STATUS,
   output logic      WRITE_DRIVE_STROBE_N,
   output logic      WRITE_STROBE_N_OUT,
   output logic      WRITE_STROBE_N_OE_N,
   output logic      ADDR_OE_N,
   output logic      PROCESSOR_STOP
);

   // ----------------------------------------------------------------
   // Phase tracking
   // ----------------------------------------------------------------
   logic phase_high;
   logic phase_fall;

   basout_phase u_phase
   (
      .clk        (CLK),
      .srst       (SRST),
      .phase_in   (PROCESSOR_PHASE_CLOCK),
      .phase_high (phase_high),
      .phase_fall (phase_fall)
   );

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed
   {
      basout_bus_e bus;
      logic        status;
      logic        strobe_n;
      logic        wstrobe;
      logic        wstrobe_oe_n;
      logic        addr_oe_n;
      logic        stop;
   } basout_state_s;

   basout_state_s st_reg;
   basout_state_s st_next;

   logic owns_bus;
   logic drive_write;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      st_next     = st_reg;
      owns_bus    = 1'h0;
      drive_write = 1'h0;

      // Bus grant: pins turn to inputs only while grant is low in low phase
      case (st_reg.bus)
         BASOUT_OWN:
         begin
            if (!EXTERNAL_BUS_GRANT && !phase_high)
            begin
               st_next.bus = BASOUT_RELEASED;
            end
            else if (!EXTERNAL_BUS_GRANT)
            begin
               st_next.bus = BASOUT_STALL;
            end
         end
         BASOUT_STALL:
         begin
            // Grant dropped in high phase: stop only, keep direction
            if (EXTERNAL_BUS_GRANT)
            begin
               st_next.bus = BASOUT_OWN;
            end
            else if (!phase_high)
            begin
               st_next.bus = BASOUT_RELEASED;
            end
         end
         BASOUT_RELEASED:
         begin
            if (EXTERNAL_BUS_GRANT)
            begin
               st_next.bus = BASOUT_OWN;
            end
         end
         default:
         begin
            st_next.bus = BASOUT_RELEASED;
         end
      endcase

      owns_bus    = (st_next.bus != BASOUT_RELEASED);
      drive_write = phase_high && CPU_EXT_WRITE && owns_bus;

      // Write-drive strobe, only meaningful in the high phase
      st_next.strobe_n = ~drive_write;

      // Shared status pin multiplexed by phase and trace mode
      if (!phase_high)
      begin
         st_next.status = ~CPU_EXT_BUS;
      end
      else if (EMULATION_TRACE_BIT)
      begin
         st_next.status = ~drive_write;
      end
      else
      begin
         st_next.status = 1'h1;
      end

      // Direction of address bus and write strobe
      if (!owns_bus)
      begin
         st_next.addr_oe_n    = 1'h1;
         st_next.wstrobe_oe_n = 1'h1;
      end
      else
      begin
         // Trace mode keeps addresses visible for an emulator
         st_next.addr_oe_n    =
            ~(EMULATION_TRACE_BIT || CPU_EXT_BUS);
         st_next.wstrobe_oe_n = 1'h0;
      end
      st_next.wstrobe = CPU_WRITE_STROBE_N;

      // Processor halted while grant is low, in either state
      st_next.stop = (st_next.bus != BASOUT_OWN);
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         st_reg.bus          <= BASOUT_BUS_RST;
         st_reg.status       <= BASOUT_STATUS_RST;
         st_reg.strobe_n     <= BASOUT_STROBE_RST;
         st_reg.wstrobe      <= BASOUT_WSTROBE_RST;
         st_reg.wstrobe_oe_n <= BASOUT_OE_N_RST;
         st_reg.addr_oe_n    <= BASOUT_OE_N_RST;
         st_reg.stop         <= BASOUT_STOP_RST;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, all straight from flip-flops
   // ----------------------------------------------------------------
   assign BUS_STATUS           = st_reg.status;
   assign WRITE_DRIVE_STROBE_N = st_reg.strobe_n;
   assign WRITE_STROBE_N_OUT   = st_reg.wstrobe;
   assign WRITE_STROBE_N_OE_N  = st_reg.wstrobe_oe_n;
   assign ADDR_OE_N            = st_reg.addr_oe_n;
   assign PROCESSOR_STOP       = st_reg.stop;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (SRST);

   sequence grant_low_in_low;
      !phase_high && !EXTERNAL_BUS_GRANT;
   endsequence

   sequence grant_held_low;
      !EXTERNAL_BUS_GRANT;
   endsequence

   internal_high_a: assert property
      ((!phase_high && !CPU_EXT_BUS) |=> BUS_STATUS)
      else $error("Status not high during internal bus use");

   external_low_a: assert property
      ((!phase_high && CPU_EXT_BUS) |=> !BUS_STATUS)
      else $error("Status not low during external bus use");

   strobe_write_a: assert property
      ((phase_high && CPU_EXT_WRITE && EXTERNAL_BUS_GRANT)
         |=> !WRITE_DRIVE_STROBE_N)
      else $error("Write-drive strobe missing on external write");

   // Strobe belongs to the high phase only
   strobe_release_a: assert property
      (phase_fall |=> WRITE_DRIVE_STROBE_N)
      else $error("Write-drive strobe held into low phase");

   trace_mux_a: assert property
      ((phase_high && EMULATION_TRACE_BIT && EXTERNAL_BUS_GRANT)
         |=> (BUS_STATUS == WRITE_DRIVE_STROBE_N))
      else $error("Trace mode high phase does not carry the strobe");

   normal_high_a: assert property
      ((phase_high && !EMULATION_TRACE_BIT) |=> BUS_STATUS)
      else $error("Normal mode high phase not at one");

   grant_release_a: assert property
      ((grant_low_in_low ##1 grant_held_low)
         |=> (ADDR_OE_N && WRITE_STROBE_N_OE_N && PROCESSOR_STOP))
      else $error("Bus not released after grant dropped");

   trace_addr_a: assert property
      ((EMULATION_TRACE_BIT && EXTERNAL_BUS_GRANT) |=> !ADDR_OE_N)
      else $error("Address bus not driven in trace mode");

endmodule

// ===== logic/basout_pkg.sv
// Shared types and reset values for the bus activity status output block.
// Assumes a single clock domain and a synchronous, active-high reset.
package basout_pkg;

   // ----------------------------------------------------------------
   // Bus ownership states, Gray coded along own -> stall -> released
   // ----------------------------------------------------------------
   typedef enum logic [1:0]
   {
      BASOUT_OWN      = 2'h0,
      BASOUT_STALL    = 2'h1,
      BASOUT_RELEASED = 2'h3
   } basout_bus_e;

   // ----------------------------------------------------------------
   // Values after reset
   // ----------------------------------------------------------------
   localparam basout_bus_e BASOUT_BUS_RST      = BASOUT_RELEASED;
   localparam logic        BASOUT_STATUS_RST   = 1'h1;
   localparam logic        BASOUT_STROBE_RST   = 1'h1;
   localparam logic        BASOUT_OE_N_RST     = 1'h1;
   localparam logic        BASOUT_STOP_RST     = 1'h0;
   localparam logic        BASOUT_PHASE_RST    = 1'h0;
   localparam logic        BASOUT_WSTROBE_RST  = 1'h1;

endpackage

// ===== logic/basout_phase.sv
// Processor clock phase tracker: registered phase level and fall pulse.
// Assumes the phase clock is sampled as a synchronous input on clk.
`timescale 1ns/100ps
module basout_phase
   import basout_pkg::*;
(
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic phase_in,
   output logic      phase_high,
   output logic      phase_fall
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed
   {
      logic cur;
      logic prev;
   } basout_phase_s;

   basout_phase_s ph_reg;
   basout_phase_s ph_next;

   always_comb
   begin
      ph_next      = ph_reg;
      ph_next.prev = ph_reg.cur;
      ph_next.cur  = phase_in;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         ph_reg.cur  <= BASOUT_PHASE_RST;
         ph_reg.prev <= BASOUT_PHASE_RST;
      end
      else
      begin
         ph_reg <= ph_next;
      end
   end

   assign phase_high = ph_reg.cur;
   // Marks the first sample of the low phase
   assign phase_fall = ph_reg.prev & ~ph_reg.cur;

endmodule

// ===== verification/basout_master.sv
// External bus master model that asks for the bus through the grant input.
// Assumes it shares the clock of the status block.
`timescale 1ns/100ps
module basout_master
(
   input  wire logic  clk,
   input  wire logic  want_bus,
   input  wire logic  strobe_n,
   output logic       grant,
   output logic       drv_en,
   output logic [7:0] addr_samples
);
   // ----------------------------------------------------------------
   // Bus request and driver control
   // ----------------------------------------------------------------
   initial grant = 1'h1;
   initial addr_samples = 8'h00;
   // Status pin alone gives no access
   always @(posedge clk) grant <= ~want_bus;
   // Drivers off while processor writes
   assign drv_en = want_bus & strobe_n;
   // Strobe fall used as address marker
   always @(negedge strobe_n) addr_samples <= addr_samples + 8'h01;
endmodule

// ===== verification/tb.sv
// Self-checking bench for the bus activity status output block.
// Assumes outputs settle within four clocks of a steady input set.
`timescale 1ns/100ps
module tb;
   import basout_pkg::*;
   logic       clk = 1'h0;
   logic       srst = 1'h1;
   logic       ph = 1'h0;
   logic       eb = 1'h0;
   logic       ew = 1'h0;
   logic       tr = 1'h0;
   logic       want = 1'h0;
   logic       grant, drv_en, st, wds_n, ws_out, ws_oe_n, a_oe_n, stop;
   logic [7:0] samples;
   int         err_total = 0;
   int         total_checks = 0;

   always #20 clk = ~clk;

   basout_top DUT (.CLK(clk), .SRST(srst), .PROCESSOR_PHASE_CLOCK(ph),
      .CPU_EXT_BUS(eb), .CPU_EXT_WRITE(ew), .CPU_WRITE_STROBE_N(~ew),
      .EMULATION_TRACE_BIT(tr), .EXTERNAL_BUS_GRANT(grant),
      .BUS_STATUS(st), .WRITE_DRIVE_STROBE_N(wds_n),
      .WRITE_STROBE_N_OUT(ws_out), .WRITE_STROBE_N_OE_N(ws_oe_n),
      .ADDR_OE_N(a_oe_n), .PROCESSOR_STOP(stop));

   basout_master master (.clk(clk), .want_bus(want), .strobe_n(wds_n),
      .grant(grant), .drv_en(drv_en), .addr_samples(samples));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input string name, input logic exp, input logic got);
      total_checks++;
      if (got !== exp)
      begin
         $display("[FAIL] %s expected %b seen %b", name, exp, got);
         err_total++;
      end
   endtask

   // Steady inputs for four clocks, then sample settled outputs
   task automatic drive(input logic p, b, w, t, g);
      @(posedge clk);
      ph <= p;
      eb <= b;
      ew <= w;
      tr <= t;
      want <= g;
      repeat (4) @(posedge clk);
      #1;
   endtask

   task automatic final_report;
      if (err_total == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_normal;
      drive(0, 0, 0, 0, 0);
      chk("status internal", 1'h1, st);
      chk("addr idle", 1'h1, a_oe_n);
      drive(0, 1, 0, 0, 0);
      chk("status external", 1'h0, st);
      drive(1, 1, 1, 0, 0);
      chk("status high normal", 1'h1, st);
      chk("strobe write", 1'h0, wds_n);
      chk("wstrobe pin", 1'h0, ws_out);
   endtask

   task automatic t_trace;
      logic [7:0] s0;
      // Strobe must rise first, else no fall reaches the marker
      drive(1, 1, 0, 1, 0);
      chk("pin no write", 1'h1, st);
      chk("strobe idle", 1'h1, wds_n);
      s0 = samples;
      drive(1, 1, 1, 1, 0);
      chk("pin strobe", 1'h0, st);
      chk("strobe write", 1'h0, wds_n);
      chk("marker", 1'h1, samples != s0);
      drive(0, 0, 0, 1, 0);
      chk("pin low phase", 1'h1, st);
      chk("addr traced", 1'h0, a_oe_n);
   endtask

   // Grant in high phase only stalls; low phase turns pins around
   task automatic t_grant;
      drive(1, 1, 0, 1, 1);
      chk("stall stop", 1'h1, stop);
      chk("stall addr", 1'h0, a_oe_n);
      drive(0, 1, 0, 1, 1);
      chk("grant addr", 1'h1, a_oe_n);
      chk("grant wstrobe", 1'h1, ws_oe_n);
      chk("grant stop", 1'h1, stop);
      drive(0, 1, 0, 1, 0);
      chk("back stop", 1'h0, stop);
      chk("back wstrobe", 1'h0, ws_oe_n);
      chk("back addr", 1'h0, a_oe_n);
   endtask

   initial
   begin
      #80000;
      err_total++;
      final_report();
   end

   initial
   begin
      repeat (2) @(posedge clk);
      srst <= 1'h0;
      #1;
      chk("reset status", BASOUT_STATUS_RST, st);
      chk("reset strobe", BASOUT_STROBE_RST, wds_n);
      chk("reset addr", BASOUT_OE_N_RST, a_oe_n);
      chk("reset stop", BASOUT_STOP_RST, stop);
      chk("reset wstrobe", BASOUT_WSTROBE_RST, ws_out);
      chk("reset wstrobe oe", BASOUT_OE_N_RST, ws_oe_n);
      t_normal();
      t_trace();
      t_grant();
      final_report();
   end
endmodule
